// [pkg/dssh_pkg.sv]
`default_nettype none
package dssh_pkg;
	// Register map (management register indices).
	localparam logic [15:0] DSSH_STATUS_ADDR    = 16'h001B;
	localparam logic [15:0] DSSH_HYS_CTRL_ADDR  = 16'h001C;
	localparam logic [15:0] DSSH_STATUS_RESET   = 16'h1020;
	localparam logic [15:0] DSSH_HYS_CTRL_RESET = 16'h0000;

	// Status register field positions.
	localparam int DSSH_TX_SRC_LSB  = 12;
	localparam int DSSH_TX_PEND_BIT = 11;
	localparam int DSSH_TX_DONE_BIT = 10;
	localparam int DSSH_TX_ON_BIT   = 9;
	localparam int DSSH_TX_OFF_BIT  = 8;
	localparam int DSSH_RX_SRC_LSB  = 4;
	localparam int DSSH_RX_PEND_BIT = 3;
	localparam int DSSH_RX_DONE_BIT = 2;
	localparam int DSSH_RX_ON_BIT   = 1;
	localparam int DSSH_RX_OFF_BIT  = 0;
	localparam int DSSH_SRC_W       = 4;

	// Hysteresis control field position.
	localparam int DSSH_HYS_SEL_LSB = 0;
	localparam int DSSH_HYS_SEL_W   = 2;

	typedef enum logic [1:0] {
		DSSH_HYS_STANDARD = 2'h0,
		DSSH_HYS_ONE      = 2'h1,
		DSSH_HYS_TWO      = 2'h2,
		DSSH_HYS_THREE    = 2'h3
	} dssh_hys_mode_t;

	// Report from one direction of the data switch.
	typedef struct packed {
		logic [3:0] source_onehot;
		logic       switch_pending;
		logic       switch_done;
		logic       on_seen;
		logic       off_seen;
	} dssh_switch_report_t;
endpackage : dssh_pkg
`default_nettype wire

// [rtl/dssh_status_sync_hys.sv]
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Transmit source reported one-hot, bits 15:12.
// - Receive source reported one-hot, bits 7:4.
// - Transmit pending bit follows live switch state.
// - Receive pending bit follows live switch state.
// - Transmit switch done latched high.
// - Receive switch done latched high.
// - Transmit ON trigger latched high.
// - Transmit OFF trigger latched high.
// - Receive ON trigger latched high.
// - Receive OFF trigger latched high.
// - Select zero keeps standard synchronizer hysteresis.
// - Select one drops sync on one error.
// - Select two drops sync on two errors.
// - Select three drops sync on three errors.
// - Hysteresis setting addressed through selected lane.
module dssh_status_sync_hys
	import dssh_pkg::*;
#(
	parameter int LANES    = 4,
	parameter int LANE_SEL = (LANES > 1) ? $clog2(LANES) : 1
) (
	input  wire logic                i_sys_clk,
	input  wire logic                i_reset_n,
	input  wire logic [15:0]         i_reg_addr,
	input  wire logic                i_reg_wr,
	input  wire logic                i_reg_rd,
	input  wire logic [15:0]         i_reg_wdata,
	output logic      [15:0]         o_reg_rdata,
	output logic                     o_reg_rvalid,
	input  wire logic [LANE_SEL-1:0] i_lane_select,
	input  wire dssh_switch_report_t i_tx_switch,
	input  wire dssh_switch_report_t i_rx_switch,
	input  wire logic [LANES-1:0]    i_lane_char_strobe,
	input  wire logic [LANES-1:0]    i_lane_char_err,
	input  wire logic [LANES-1:0]    i_lane_in_sync,
	output logic      [LANES-1:0]    o_lane_force_los,
	output logic      [LANES-1:0]    o_lane_std_hysteresis
);

	// A flag sets on its event and clears on a read; an event in the read cycle wins.
	function automatic logic latch_next(input logic flag, input logic evt, input logic clr);
		latch_next = evt | (flag & ~clr);
	endfunction : latch_next

	// Number of adjacent errors that forces loss of sync; zero means standard hysteresis.
	function automatic logic [1:0] hys_threshold(input logic [1:0] sel);
		unique case (dssh_hys_mode_t'(sel))
			DSSH_HYS_ONE:   hys_threshold = 2'h1;
			DSSH_HYS_TWO:   hys_threshold = 2'h2;
			DSSH_HYS_THREE: hys_threshold = 2'h3;
			default:        hys_threshold = 2'h0;
		endcase
	endfunction : hys_threshold

	// Register decode.
	wire logic hit_status  = (i_reg_addr == DSSH_STATUS_ADDR);
	wire logic hit_hys     = (i_reg_addr == DSSH_HYS_CTRL_ADDR);
	wire logic status_read = i_reg_rd & hit_status;
	wire logic hys_write   = i_reg_wr & hit_hys;

	// Switch status state.
	logic [3:0] tx_src_reg;
	logic [3:0] rx_src_reg;
	logic       tx_pend_reg;
	logic       rx_pend_reg;
	logic       tx_done_reg;
	logic       rx_done_reg;
	logic       tx_on_reg;
	logic       tx_off_reg;
	logic       rx_on_reg;
	logic       rx_off_reg;

	logic tx_done_next;
	logic rx_done_next;
	logic tx_on_next;
	logic tx_off_next;
	logic rx_on_next;
	logic rx_off_next;

	assign tx_done_next = latch_next(tx_done_reg, i_tx_switch.switch_done, status_read);
	assign rx_done_next = latch_next(rx_done_reg, i_rx_switch.switch_done, status_read);
	assign tx_on_next   = latch_next(tx_on_reg, i_tx_switch.on_seen, status_read);
	assign tx_off_next  = latch_next(tx_off_reg, i_tx_switch.off_seen, status_read);
	assign rx_on_next   = latch_next(rx_on_reg, i_rx_switch.on_seen, status_read);
	assign rx_off_next  = latch_next(rx_off_reg, i_rx_switch.off_seen, status_read);

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			tx_src_reg  <= DSSH_STATUS_RESET[DSSH_TX_SRC_LSB +: DSSH_SRC_W];
			rx_src_reg  <= DSSH_STATUS_RESET[DSSH_RX_SRC_LSB +: DSSH_SRC_W];
			tx_pend_reg <= DSSH_STATUS_RESET[DSSH_TX_PEND_BIT];
			rx_pend_reg <= DSSH_STATUS_RESET[DSSH_RX_PEND_BIT];
		end else begin
			tx_src_reg  <= i_tx_switch.source_onehot;
			rx_src_reg  <= i_rx_switch.source_onehot;
			tx_pend_reg <= i_tx_switch.switch_pending;
			rx_pend_reg <= i_rx_switch.switch_pending;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			tx_done_reg <= DSSH_STATUS_RESET[DSSH_TX_DONE_BIT];
			rx_done_reg <= DSSH_STATUS_RESET[DSSH_RX_DONE_BIT];
			tx_on_reg   <= DSSH_STATUS_RESET[DSSH_TX_ON_BIT];
			tx_off_reg  <= DSSH_STATUS_RESET[DSSH_TX_OFF_BIT];
			rx_on_reg   <= DSSH_STATUS_RESET[DSSH_RX_ON_BIT];
			rx_off_reg  <= DSSH_STATUS_RESET[DSSH_RX_OFF_BIT];
		end else begin
			tx_done_reg <= tx_done_next;
			rx_done_reg <= rx_done_next;
			tx_on_reg   <= tx_on_next;
			tx_off_reg  <= tx_off_next;
			rx_on_reg   <= rx_on_next;
			rx_off_reg  <= rx_off_next;
		end
	end

	// An event arriving with the read is reported by that read as well as kept.
	logic [15:0] status_word;
	always_comb begin
		status_word                                   = 16'h0000;
		status_word[DSSH_TX_SRC_LSB +: DSSH_SRC_W]    = tx_src_reg;
		status_word[DSSH_TX_PEND_BIT]                 = tx_pend_reg;
		status_word[DSSH_TX_DONE_BIT]                 = tx_done_reg | i_tx_switch.switch_done;
		status_word[DSSH_TX_ON_BIT]                   = tx_on_reg | i_tx_switch.on_seen;
		status_word[DSSH_TX_OFF_BIT]                  = tx_off_reg | i_tx_switch.off_seen;
		status_word[DSSH_RX_SRC_LSB +: DSSH_SRC_W]    = rx_src_reg;
		status_word[DSSH_RX_PEND_BIT]                 = rx_pend_reg;
		status_word[DSSH_RX_DONE_BIT]                 = rx_done_reg | i_rx_switch.switch_done;
		status_word[DSSH_RX_ON_BIT]                   = rx_on_reg | i_rx_switch.on_seen;
		status_word[DSSH_RX_OFF_BIT]                  = rx_off_reg | i_rx_switch.off_seen;
	end

	// Per-lane hysteresis selection, reached through the lane select.
	logic [1:0] hys_sel_reg [LANES];
	logic [1:0] hys_sel_selected;
	assign hys_sel_selected = hys_sel_reg[i_lane_select];

	logic [15:0] hys_word;
	always_comb begin
		hys_word                                        = 16'h0000;
		hys_word[DSSH_HYS_SEL_LSB +: DSSH_HYS_SEL_W]    = hys_sel_selected;
	end

	logic [15:0] rdata_next;
	assign rdata_next = hit_status ? status_word : (hit_hys ? hys_word : 16'h0000);

	always_ff @(posedge i_sys_clk) begin
		if (!i_reset_n) begin
			o_reg_rdata  <= 16'h0000;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd) begin
				o_reg_rdata <= rdata_next;
			end
		end
	end

	// Error hysteresis per lane.
	logic [1:0] err_cnt_reg [LANES];

	genvar g;
	generate
		for (g = 0; g < LANES; g++) begin : g_lane
			wire logic       lane_wr   = hys_write & (i_lane_select == LANE_SEL'(g));
			wire logic [1:0] threshold = hys_threshold(hys_sel_reg[g]);
			wire logic [2:0] cnt_inc   = {1'b0, err_cnt_reg[g]} + 3'h1;
			wire logic       bad_char  = i_lane_char_strobe[g] & i_lane_char_err[g] & i_lane_in_sync[g];
			wire logic       good_char = i_lane_char_strobe[g] & ~i_lane_char_err[g];
			wire logic       trip      = bad_char & (threshold != 2'h0) & (cnt_inc >= {1'b0, threshold});

			always_ff @(posedge i_sys_clk) begin
				if (!i_reset_n) begin
					hys_sel_reg[g] <= DSSH_HYS_CTRL_RESET[DSSH_HYS_SEL_LSB +: DSSH_HYS_SEL_W];
				end else if (lane_wr) begin
					hys_sel_reg[g] <= i_reg_wdata[DSSH_HYS_SEL_LSB +: DSSH_HYS_SEL_W];
				end
			end

			always_ff @(posedge i_sys_clk) begin
				if (!i_reset_n) begin
					err_cnt_reg[g]           <= 2'h0;
					o_lane_force_los[g]      <= 1'b0;
					o_lane_std_hysteresis[g] <= 1'b1;
				end else begin
					o_lane_std_hysteresis[g] <= (hys_sel_reg[g] == DSSH_HYS_STANDARD);
					o_lane_force_los[g]      <= trip;
					if (!i_lane_in_sync[g] || good_char || trip || lane_wr) begin
						err_cnt_reg[g] <= 2'h0;
					end else if (bad_char && threshold != 2'h0) begin
						err_cnt_reg[g] <= cnt_inc[1:0];
					end
				end
			end
		end
	endgenerate

	// Checks on lane 0, the hysteresis readback of the selected lane and the status register.
	sequence s_err0;
		i_lane_char_strobe[0] && i_lane_char_err[0] && i_lane_in_sync[0] && !i_reg_wr;
	endsequence

	sequence s_gap0;
		!i_lane_char_strobe[0] && i_lane_in_sync[0] && !i_reg_wr;
	endsequence

	sequence s_good0;
		i_lane_char_strobe[0] && !i_lane_char_err[0] && !i_reg_wr;
	endsequence

	sequence s_status_read_quiet;
		status_read && !i_tx_switch.switch_done && !i_rx_switch.switch_done
			&& !i_tx_switch.on_seen && !i_tx_switch.off_seen
			&& !i_rx_switch.on_seen && !i_rx_switch.off_seen;
	endsequence

	a_tx_src_report: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		status_read |=> o_reg_rdata[15:12] == $past(i_tx_switch.source_onehot, 2))
		else $error("Transmit source field does not follow the switch.");

	a_rx_pend_live: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_rx_switch.switch_pending ##1 status_read |=> o_reg_rdata[3])
		else $error("Receive pending bit missing from status read.");

	a_tx_done_latch: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_tx_switch.switch_done ##1 (!status_read)[*2] ##1 status_read |=> o_reg_rdata[10])
		else $error("Transmit done flag was not held until read.");

	a_rx_on_latch: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_rx_switch.on_seen || (rx_on_reg && !status_read) |=> rx_on_reg)
		else $error("Receive ON flag dropped before a read.");

	a_read_clears: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_status_read_quiet |=> !tx_done_reg && !rx_done_reg && !tx_on_reg
			&& !tx_off_reg && !rx_on_reg && !rx_off_reg)
		else $error("Latched flags not cleared by a status read.");

	a_set_wins: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		status_read && i_tx_switch.off_seen |=> tx_off_reg)
		else $error("Transmit OFF event lost in its read cycle.");

	a_std_no_force: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		hys_sel_reg[0] == 2'h0 |=> !o_lane_force_los[0])
		else $error("Loss of sync forced in standard hysteresis mode.");

	a_hys_one: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		((hys_sel_reg[0] == 2'h1) and s_err0) |=> o_lane_force_los[0])
		else $error("Single error did not force loss of sync.");

	a_hys_two: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		((hys_sel_reg[0] == 2'h2 && err_cnt_reg[0] == 2'h0) and s_err0) ##1 s_err0 |=> o_lane_force_los[0])
		else $error("Two adjacent errors did not force loss of sync.");

	a_hys_three: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		((hys_sel_reg[0] == 2'h3 && err_cnt_reg[0] == 2'h0) and s_err0) ##1 s_err0 ##1 s_err0
			|=> o_lane_force_los[0] && $past(!o_lane_force_los[0]))
		else $error("Three adjacent errors did not force loss of sync.");

	a_lane_write: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		hys_write && i_lane_select == LANE_SEL'(0) |=> hys_sel_reg[0] == $past(i_reg_wdata[1:0]))
		else $error("Hysteresis write missed the selected lane.");

	a_rx_src_report: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		status_read |=> o_reg_rdata[7:4] == $past(i_rx_switch.source_onehot, 2))
		else $error("Receive source field does not follow the switch.");

	a_tx_pend_live: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_tx_switch.switch_pending ##1 status_read |=> o_reg_rdata[11])
		else $error("Transmit pending bit missing from status read.");

	a_tx_pend_clear: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		!i_tx_switch.switch_pending ##1 status_read |=> !o_reg_rdata[11])
		else $error("Transmit pending bit reported without a pending switch.");

	a_rx_pend_clear: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		!i_rx_switch.switch_pending ##1 status_read |=> !o_reg_rdata[3])
		else $error("Receive pending bit reported without a pending switch.");

	a_tx_done_hold: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_tx_switch.switch_done || (tx_done_reg && !status_read) |=> tx_done_reg)
		else $error("Transmit done flag dropped before a read.");

	a_rx_done_hold: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_rx_switch.switch_done || (rx_done_reg && !status_read) |=> rx_done_reg)
		else $error("Receive done flag dropped before a read.");

	a_tx_on_hold: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_tx_switch.on_seen || (tx_on_reg && !status_read) |=> tx_on_reg)
		else $error("Transmit ON flag dropped before a read.");

	a_tx_off_hold: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_tx_switch.off_seen || (tx_off_reg && !status_read) |=> tx_off_reg)
		else $error("Transmit OFF flag dropped before a read.");

	a_rx_off_hold: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_rx_switch.off_seen || (rx_off_reg && !status_read) |=> rx_off_reg)
		else $error("Receive OFF flag dropped before a read.");

	a_rx_done_report: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		status_read && rx_done_reg |=> o_reg_rdata[2])
		else $error("Receive done flag missing from status read.");

	a_tx_on_report: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		status_read && tx_on_reg |=> o_reg_rdata[9])
		else $error("Transmit ON flag missing from status read.");

	a_tx_off_report: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		status_read && tx_off_reg |=> o_reg_rdata[8])
		else $error("Transmit OFF flag missing from status read.");

	a_rx_on_report: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		status_read && rx_on_reg |=> o_reg_rdata[1])
		else $error("Receive ON flag missing from status read.");

	a_rx_off_report: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		status_read && rx_off_reg |=> o_reg_rdata[0])
		else $error("Receive OFF flag missing from status read.");

	a_std_flag_on: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		hys_sel_reg[0] == 2'h0 |=> o_lane_std_hysteresis[0])
		else $error("Standard hysteresis flag low with select zero.");

	a_std_flag_off: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		hys_sel_reg[0] != 2'h0 |=> !o_lane_std_hysteresis[0])
		else $error("Standard hysteresis flag high with a counted select.");

	a_hys_two_gap: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		((hys_sel_reg[0] == 2'h2 && err_cnt_reg[0] == 2'h0) and s_err0) ##1 s_gap0 ##1 s_err0
			|=> o_lane_force_los[0])
		else $error("Two errors apart by an idle cycle did not force loss of sync.");

	a_hys_three_gap: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		((hys_sel_reg[0] == 2'h3 && err_cnt_reg[0] == 2'h0) and s_err0) ##1 s_gap0 ##1 s_err0
			##1 s_gap0 ##1 s_err0 |=> o_lane_force_los[0])
		else $error("Three errors apart by idle cycles did not force loss of sync.");

	a_good_restarts: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		((hys_sel_reg[0] == 2'h3 && err_cnt_reg[0] == 2'h0) and s_err0) ##1 s_gap0 ##1 s_err0
			##1 s_gap0 ##1 s_good0 ##1 s_gap0 ##1 s_err0 |=> !o_lane_force_los[0])
		else $error("Good character did not restart the error count.");

	a_lane_other: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		hys_write && i_lane_select != LANE_SEL'(0) |=> $stable(hys_sel_reg[0]))
		else $error("Hysteresis write reached an unselected lane.");

	a_hys_readback: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_reg_rd && hit_hys |=> o_reg_rdata == {14'h0000, $past(hys_sel_reg[i_lane_select])})
		else $error("Hysteresis read does not show the selected lane.");

	a_write_clears: assert property (@(posedge i_sys_clk) disable iff (!i_reset_n)
		hys_write && i_lane_select == LANE_SEL'(0) |=> err_cnt_reg[0] == 2'h0)
		else $error("Hysteresis write left an error count behind.");

endmodule : dssh_status_sync_hys
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import dssh_pkg::*;
	logic                i_sys_clk = 1'b0;
	logic                i_reset_n = 1'b0;
	logic [15:0]         addr      = 16'h0000;
	logic [15:0]         wdata     = 16'h0000;
	logic                rd        = 1'b0;
	logic                wr        = 1'b0;
	logic [1:0]          lsel      = 2'h0;
	dssh_switch_report_t txs       = 8'h10;
	dssh_switch_report_t rxs       = 8'h20;
	logic [3:0]          stb       = 4'h0;
	logic [3:0]          err       = 4'h0;
	logic [3:0]          insync    = 4'hF;
	logic [15:0]         rdata;
	logic                rvalid;
	logic [3:0]          flos;
	logic [3:0]          stdh;
	int                  fails     = 0;
	int                  tests_run = 0;

	always #2.5 i_sys_clk = ~i_sys_clk;

	dssh_status_sync_hys #(.LANES(4)) uut (
		.i_sys_clk             (i_sys_clk),
		.i_reset_n             (i_reset_n),
		.i_reg_addr            (addr),
		.i_reg_wr              (wr),
		.i_reg_rd              (rd),
		.i_reg_wdata           (wdata),
		.o_reg_rdata           (rdata),
		.o_reg_rvalid          (rvalid),
		.i_lane_select         (lsel),
		.i_tx_switch           (txs),
		.i_rx_switch           (rxs),
		.i_lane_char_strobe    (stb),
		.i_lane_char_err       (err),
		.i_lane_in_sync        (insync),
		.o_lane_force_los      (flos),
		.o_lane_std_hysteresis (stdh)
	);

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge i_sys_clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge i_sys_clk);
		wr = 1'b0;
	endtask : reg_wr

	// Read data and valid are both looked at in the one cycle that valid stands.
	task automatic reg_rd(input logic [15:0] a, input logic [15:0] exp, input string nm);
		@(negedge i_sys_clk);
		addr = a;
		rd = 1'b1;
		@(negedge i_sys_clk);
		rd = 1'b0;
		check("read_valid", {15'h0000, rvalid}, 16'h0001);
		check(nm, rdata, exp);
	endtask : reg_rd

	// One character on a lane; the loss-of-sync pulse is expected the cycle after it.
	task automatic chr(input int l, input logic e, input logic los);
		@(negedge i_sys_clk);
		stb[l] = 1'b1;
		err[l] = e;
		@(negedge i_sys_clk);
		stb = 4'h0;
		err = 4'h0;
		check("force_los", {12'h000, flos}, {12'h000, 4'(los) << l});
	endtask : chr

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : tally_and_finish

	initial begin
		#100000;
		fails++;
		tally_and_finish();
	end

	initial begin
		logic [3:0] e;
		repeat (10) @(posedge i_sys_clk);
		@(negedge i_sys_clk);
		i_reset_n = 1'b1;
		reg_rd(DSSH_STATUS_ADDR, DSSH_STATUS_RESET, "status_reset");
		reg_rd(DSSH_HYS_CTRL_ADDR, DSSH_HYS_CTRL_RESET, "hys_reset");
		reg_rd(16'h001D, 16'h0000, "unmapped");
		check("std_hys_reset", {12'h000, stdh}, 16'h000F);
		reg_wr(DSSH_STATUS_ADDR, 16'hFFFF);
		reg_rd(DSSH_STATUS_ADDR, DSSH_STATUS_RESET, "status_ro");
		$display("test reset_and_access done");
		for (int i = 0; i < 4; i++) begin
			@(negedge i_sys_clk);
			txs = {4'h1 << i, 4'h8};
			rxs = {4'h8 >> i, 4'(i[0]) << 3};
			reg_rd(DSSH_STATUS_ADDR, {txs, rxs}, "source_pending");
		end
		txs = 8'h10;
		rxs = 8'h20;
		$display("test source_and_pending done");
		for (int f = 0; f < 6; f++) begin
			@(negedge i_sys_clk);
			if (f < 3)
				txs[f] = 1'b1;
			else
				rxs[f - 3] = 1'b1;
			@(negedge i_sys_clk);
			txs = 8'h10;
			rxs = 8'h20;
			@(negedge i_sys_clk);
			reg_rd(DSSH_STATUS_ADDR, 16'h1020 | (16'h0001 << ((f < 3) ? f + 8 : f - 3)), "flag_set");
			reg_rd(DSSH_STATUS_ADDR, 16'h1020, "flag_clear");
		end
		$display("test latched_flags done");
		txs[0] = 1'b1;
		reg_rd(DSSH_STATUS_ADDR, 16'h1120, "set_in_read");
		txs = 8'h10;
		reg_rd(DSSH_STATUS_ADDR, 16'h1120, "set_kept");
		reg_rd(DSSH_STATUS_ADDR, 16'h1020, "set_cleared");
		$display("test set_wins done");
		for (int l = 0; l < 4; l++) begin
			for (int s = 1; s < 4; s++) begin
				lsel = 2'(l);
				reg_wr(DSSH_HYS_CTRL_ADDR, 16'hFFFC | 16'(s));
				reg_rd(DSSH_HYS_CTRL_ADDR, 16'(s), "hys_select");
				e = 4'hF << (l + 1);
				check("std_hys", {12'h000, stdh}, {12'h000, e});
				for (int k = 1; k <= s; k++)
					chr(l, 1'b1, k == s);
			end
		end
		chr(0, 1'b1, 1'b0);
		chr(0, 1'b1, 1'b0);
		chr(0, 1'b0, 1'b0);
		chr(0, 1'b1, 1'b0);
		chr(0, 1'b1, 1'b0);
		chr(0, 1'b1, 1'b1);
		lsel = 2'h0;
		reg_wr(DSSH_HYS_CTRL_ADDR, 16'h0000);
		@(negedge i_sys_clk);
		check("std_hys_lane0", {12'h000, stdh}, 16'h0001);
		for (int k = 0; k < 4; k++)
			chr(0, 1'b1, 1'b0);
		lsel = 2'h1;
		reg_rd(DSSH_HYS_CTRL_ADDR, 16'h0003, "hys_other_lane");
		$display("test lane_hysteresis done");
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
